// [rtl/aprt_top.sv]
// alert pin routing: routing registers, alert pins, interrupt
`timescale 1ns/1ps
`default_nettype none

// Function
// - first pin routes channel 2-4 overpower
// - bit 3 routes accumulator fullness
// - bit 2 routes sample count fullness
// - bit 1 gives pulse per conversion
// - pulse needs alert function; slow lost
// - bit 0 always reads zero
// - second route register at 28H, zero reset
// - second register acts only in alert mode
// - bits 23-20 route overcurrent
// - bits 19-16 route undercurrent
// - bits 15-8 route over/undervoltage
// - low bits route power, fullness, pulse
module aprt_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [aprt_pkg::ADDR_W-1:0] addr_i,
   input wire logic [aprt_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [aprt_pkg::DATA_W-1:0] rdata_o,
   // monitor conditions
   input wire aprt_pkg::aprt_cond_t cond_i,
   input wire logic conv_done_i,
   // first multi-function pin
   input wire logic pin1_i,
   output logic pin1_o,
   output logic pin1_oe_n_o,
   output logic slow_mode_o,
   // second multi-function pin
   output logic pin2_o,
   output logic pin2_oe_n_o,
   // interrupt
   output logic irq_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // one routed hit decision, shared by both pins
   function automatic logic route_hit(input logic [23:0] cond_vec,
                                      input logic [23:0] route,
                                      input logic [23:0] enable);
      logic [23:0] en_eff;
      en_eff = enable;
      en_eff[aprt_pkg::BIT_CC] = 1'b1; // conversion pulse is not a limit alert
      route_hit = |(cond_vec & route & en_eff & aprt_pkg::ROUTE_MASK);
   endfunction

   // ----------------------------------------------------------------
   // conversion pulse
   // ----------------------------------------------------------------

   logic cc_pulse;

   aprt_pulse #(
      .CYCLES(aprt_pkg::PULSE_CYCLES)
   ) u_pulse (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(conv_done_i),
      .pulse_o(cc_pulse)
   );

   // ----------------------------------------------------------------
   // condition vector in register layout
   // ----------------------------------------------------------------

   logic [23:0] cond_vec;

   // bit 0 stays zero: nothing is routed through the unimplemented bit
   assign cond_vec = {cond_i.oc, cond_i.uc, cond_i.ov, cond_i.uv, cond_i.op,
                      cond_i.acc_full, cond_i.cnt_full, cc_pulse, 1'b0};

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   aprt_pkg::aprt_state_t s_reg;
   aprt_pkg::aprt_state_t s_next;
   logic wr_route1;
   logic wr_route2;
   logic wr_en;
   logic wr_fn;
   logic wr_stat;
   logic wr_mask;
   logic hit1;
   logic hit2;
   logic fn1;
   logic fn2;
   logic [2:0] events;

   // address decode; strobes never overlap
   assign wr_route1 = wr_i && (addr_i == aprt_pkg::OFS_ROUTE1);
   assign wr_route2 = wr_i && (addr_i == aprt_pkg::OFS_ROUTE2);
   assign wr_en = wr_i && (addr_i == aprt_pkg::OFS_ALERT_EN);
   assign wr_fn = wr_i && (addr_i == aprt_pkg::OFS_PIN_FN);
   assign wr_stat = wr_i && (addr_i == aprt_pkg::OFS_IRQ_STAT);
   assign wr_mask = wr_i && (addr_i == aprt_pkg::OFS_IRQ_MASK);

   // pin decisions use the stored registers, so a write acts one cycle later
   assign fn1 = s_reg.pin_fn[aprt_pkg::FN_PIN1];
   assign fn2 = s_reg.pin_fn[aprt_pkg::FN_PIN2];
   assign hit1 = route_hit(cond_vec, s_reg.route1, s_reg.alert_en);
   assign hit2 = route_hit(cond_vec, s_reg.route2, s_reg.alert_en);

   // next state
   always_comb begin
      s_next = s_reg;
      events = '0;

      // register writes; bit 0 of the route and enable registers is masked off so it always reads zero
      if (wr_route1) begin
         s_next.route1 = wdata_i & aprt_pkg::ROUTE_MASK;
      end
      if (wr_route2) begin
         s_next.route2 = wdata_i & aprt_pkg::ROUTE_MASK;
      end
      if (wr_en) begin
         s_next.alert_en = wdata_i & aprt_pkg::ROUTE_MASK;
      end
      if (wr_fn) begin
         s_next.pin_fn = wdata_i[1:0];
      end
      if (wr_mask) begin
         s_next.irq_mask = wdata_i[2:0];
      end

      // first pin: driven only in alert function, else it is the slow input
      if (fn1) begin
         s_next.pin1 = hit1;
         s_next.pin1_oe_n = 1'b0;
         s_next.slow = 1'b0;
      end else begin
         s_next.pin1 = 1'b0;
         s_next.pin1_oe_n = 1'b1;
         s_next.slow = pin1_i;
      end

      // second pin: routing has no effect outside alert function
      if (fn2) begin
         s_next.pin2 = hit2;
         s_next.pin2_oe_n = 1'b0;
      end else begin
         s_next.pin2 = 1'b0;
         s_next.pin2_oe_n = 1'b1;
      end

      // sticky events; a set in the clear cycle wins
      events[aprt_pkg::IRQ_CONV] = conv_done_i;
      events[aprt_pkg::IRQ_PIN1] = s_next.pin1 && !s_reg.pin1;
      events[aprt_pkg::IRQ_PIN2] = s_next.pin2 && !s_reg.pin2;
      if (wr_stat) begin
         s_next.irq_stat = s_reg.irq_stat & ~wdata_i[2:0];
      end
      s_next.irq_stat = s_next.irq_stat | events;
      s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

      // read data stands one cycle only; unmapped reads return zero
      s_next.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            aprt_pkg::OFS_ROUTE1: s_next.rdata = s_reg.route1;
            aprt_pkg::OFS_ROUTE2: s_next.rdata = s_reg.route2;
            aprt_pkg::OFS_ALERT_EN: s_next.rdata = s_reg.alert_en;
            aprt_pkg::OFS_PIN_FN: s_next.rdata = {22'h000000, s_reg.pin_fn};
            aprt_pkg::OFS_IRQ_STAT: s_next.rdata = {21'h000000, s_reg.irq_stat};
            aprt_pkg::OFS_IRQ_MASK: s_next.rdata = {21'h000000, s_reg.irq_mask};
            default: s_next.rdata = '0;
         endcase
      end
   end

   // state register; all fields clear at reset except pin1_oe_n and pin2_oe_n, which reset to one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg.route1 <= aprt_pkg::RST_ROUTE;
         s_reg.route2 <= aprt_pkg::RST_ROUTE;
         s_reg.alert_en <= aprt_pkg::RST_ROUTE;
         s_reg.pin_fn <= aprt_pkg::RST_PIN_FN;
         s_reg.irq_stat <= aprt_pkg::RST_IRQ;
         s_reg.irq_mask <= aprt_pkg::RST_IRQ;
         s_reg.rdata <= '0;
         s_reg.pin1 <= 1'b0;
         s_reg.pin2 <= 1'b0;
         s_reg.pin1_oe_n <= 1'b1;
         s_reg.pin2_oe_n <= 1'b1;
         s_reg.slow <= 1'b0;
         s_reg.irq <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // every output is a field of the state register
   assign rdata_o = s_reg.rdata;
   assign pin1_o = s_reg.pin1;
   assign pin1_oe_n_o = s_reg.pin1_oe_n;
   assign slow_mode_o = s_reg.slow;
   assign pin2_o = s_reg.pin2;
   assign pin2_oe_n_o = s_reg.pin2_oe_n;
   assign irq_o = s_reg.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------

   AST_PIN1_OVERPOWER: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn1 && |(cond_i.op[2:0] & s_reg.route1[6:4] & s_reg.alert_en[6:4]))
      |=> pin1_o)
      else $error("routed overpower did not drive first pin");

   AST_ACC_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && cond_i.acc_full && s_reg.route2[aprt_pkg::BIT_ACC]
       && s_reg.alert_en[aprt_pkg::BIT_ACC]) |=> pin2_o)
      else $error("accumulator fullness not routed");

   AST_CNT_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn1 && cond_i.cnt_full && s_reg.route1[aprt_pkg::BIT_CNT]
       && s_reg.alert_en[aprt_pkg::BIT_CNT]) |=> pin1_o)
      else $error("sample count fullness not routed");

   AST_CC_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn1 && cc_pulse && s_reg.route1[aprt_pkg::BIT_CC] && !wr_i) |=> pin1_o)
      else $error("conversion pulse missing on first pin");

   AST_SLOW_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      fn1 |=> (!slow_mode_o && !pin1_oe_n_o))
      else $error("slow input active while pin is alert");

   AST_SLOW_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
      !fn1 |=> (slow_mode_o == $past(pin1_i) && !pin1_o && pin1_oe_n_o))
      else $error("slow input not passed in slow mode");

   AST_BIT0_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && (addr_i == aprt_pkg::OFS_ROUTE1 || addr_i == aprt_pkg::OFS_ROUTE2))
      |=> (rdata_o[aprt_pkg::BIT_RSVD] == 1'b0))
      else $error("unimplemented bit read as one");

   AST_ROUTE2_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_route2 |=> (s_reg.route2 == ($past(wdata_i) & aprt_pkg::ROUTE_MASK)))
      else $error("second route register write lost");

   AST_ROUTE2_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_route2 ##1 (rd_i && addr_i == aprt_pkg::OFS_ROUTE2))
      |=> (rdata_o == ($past(wdata_i, 2) & aprt_pkg::ROUTE_MASK)))
      else $error("second route register read back wrong");

   AST_RESET_ZERO: assert property (@(posedge clk_i)
      rst_i |=> (s_reg.route1 == '0 && s_reg.route2 == '0))
      else $error("route registers not zero after reset");

   AST_PIN2_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !fn2 |=> (!pin2_o && pin2_oe_n_o))
      else $error("second pin driven outside alert function");

   AST_OC_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && |(cond_i.oc & s_reg.route2[23:20] & s_reg.alert_en[23:20])) |=> pin2_o)
      else $error("overcurrent not routed to second pin");

   AST_UC_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && |(cond_i.uc & s_reg.route2[19:16] & s_reg.alert_en[19:16])) |=> pin2_o)
      else $error("undercurrent not routed to second pin");

   AST_VOLT_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && |({cond_i.ov, cond_i.uv} & s_reg.route2[15:8] & s_reg.alert_en[15:8]))
      |=> pin2_o)
      else $error("voltage alert not routed to second pin");

   AST_LOW_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && |(cond_i.op & s_reg.route2[7:4] & s_reg.alert_en[7:4])) |=> pin2_o)
      else $error("overpower not routed to second pin");

   AST_NO_HIT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      !hit2 |=> !pin2_o)
      else $error("second pin high with no routed condition");

   AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done_i && s_reg.irq_mask[aprt_pkg::IRQ_CONV] && !wr_mask) |=> irq_o)
      else $error("unmasked conversion event did not raise interrupt");

   // further checks on pins, storage and status
   AST_ROUTE1_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_route1 |=> (s_reg.route1 == ($past(wdata_i) & aprt_pkg::ROUTE_MASK)))
      else $error("first route register write lost");

   AST_NO_HIT1_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      !hit1 |=> !pin1_o)
      else $error("first pin high with no routed condition");

   AST_HIT2_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && hit2) |=> pin2_o)
      else $error("second pin low although a condition is routed");

   AST_CC_PIN2: assert property (@(posedge clk_i) disable iff (rst_i)
      (fn2 && cc_pulse && s_reg.route2[aprt_pkg::BIT_CC]) |=> pin2_o)
      else $error("conversion pulse missing on second pin");

   // an unrouted pulse must not leak onto the pin
   AST_CC_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      (cc_pulse && !s_reg.route1[aprt_pkg::BIT_CC]
       && ((cond_vec[23:2] & s_reg.route1[23:2] & s_reg.alert_en[23:2]) == '0))
      |=> !pin1_o)
      else $error("unrouted conversion pulse reached first pin");

   AST_RSVD_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      !(s_reg.route1[aprt_pkg::BIT_RSVD] || s_reg.route2[aprt_pkg::BIT_RSVD]
        || s_reg.alert_en[aprt_pkg::BIT_RSVD]))
      else $error("unimplemented bit stored as one");

   AST_PIN2_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      fn2 |=> !pin2_oe_n_o)
      else $error("second pin not driven in alert function");

   // read data stands for one cycle only
   AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !rd_i |=> (rdata_o == '0))
      else $error("read data outside answer cycle");

   AST_FN_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == aprt_pkg::OFS_PIN_FN) |=> (rdata_o[23:2] == '0))
      else $error("pin function upper bits read as one");

   // set wins over a clear in the same cycle
   AST_CONV_STAT: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_done_i |=> s_reg.irq_stat[aprt_pkg::IRQ_CONV])
      else $error("conversion event not recorded");

   AST_STAT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.irq_stat[aprt_pkg::IRQ_CONV] && !(wr_stat && wdata_i[aprt_pkg::IRQ_CONV]))
      |=> s_reg.irq_stat[aprt_pkg::IRQ_CONV])
      else $error("status bit lost without clear");

endmodule

`default_nettype wire

// [rtl/aprt_pkg.sv]
// package: constants, register map and carrier types for alert pin routing
package aprt_pkg;

   // ----------------------------------------------------------------
   // register port geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 24;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_ROUTE1 = 8'h27;
   localparam logic [7:0] OFS_ROUTE2 = 8'h28;
   localparam logic [7:0] OFS_ALERT_EN = 8'h40;
   localparam logic [7:0] OFS_PIN_FN = 8'h41;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h42;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h43;

   // ----------------------------------------------------------------
   // routing field layout (same for both pins and the enable register)
   // ----------------------------------------------------------------
   localparam int FLD_OC_LSB = 20;
   localparam int FLD_UC_LSB = 16;
   localparam int FLD_OV_LSB = 12;
   localparam int FLD_UV_LSB = 8;
   localparam int FLD_OP_LSB = 4;
   localparam int BIT_ACC = 3;
   localparam int BIT_CNT = 2;
   localparam int BIT_CC = 1;
   localparam int BIT_RSVD = 0;
   localparam logic [23:0] ROUTE_MASK = 24'hFFFFFE;
   localparam logic [23:0] RST_ROUTE = 24'h000000;

   // ----------------------------------------------------------------
   // pin function and interrupt bits
   // ----------------------------------------------------------------
   localparam int FN_PIN1 = 0;
   localparam int FN_PIN2 = 1;
   localparam logic [1:0] RST_PIN_FN = 2'h0;
   localparam int IRQ_W = 3;
   localparam int IRQ_CONV = 0;
   localparam int IRQ_PIN1 = 1;
   localparam int IRQ_PIN2 = 2;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int PULSE_TIME_NS = 5000;
   localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W = 11;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // per-channel vectors: bit 3 is channel 1, bit 0 is channel 4
   typedef struct packed {
      logic [3:0] oc;
      logic [3:0] uc;
      logic [3:0] ov;
      logic [3:0] uv;
      logic [3:0] op;
      logic acc_full;
      logic cnt_full;
   } aprt_cond_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HIGH = 2'b10
   } aprt_pulse_st_t;

   typedef struct packed {
      aprt_pulse_st_t st;
      logic [PULSE_CNT_W-1:0] cnt;
      logic pulse;
   } aprt_pulse_state_t;

   typedef struct packed {
      logic [23:0] route1;
      logic [23:0] route2;
      logic [23:0] alert_en;
      logic [1:0] pin_fn;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [23:0] rdata;
      logic pin1;
      logic pin2;
      logic pin1_oe_n;
      logic pin2_oe_n;
      logic slow;
      logic irq;
   } aprt_state_t;

endpackage

// [rtl/aprt_pulse.sv]
// conversion-complete pulse stretcher
`timescale 1ns/1ps
`default_nettype none

module aprt_pulse #(
   parameter int CYCLES = aprt_pkg::PULSE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // trigger and stretched pulse
   input wire logic trig_i,
   output logic pulse_o
);

   aprt_pkg::aprt_pulse_state_t s_reg;
   aprt_pkg::aprt_pulse_state_t s_next;

   // retrigger restarts the count so back-to-back cycles never cut a pulse short
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         aprt_pkg::ST_IDLE: begin
            if (trig_i) begin
               s_next.st = aprt_pkg::ST_HIGH;
               s_next.cnt = aprt_pkg::PULSE_CNT_W'(CYCLES - 1);
            end
         end
         aprt_pkg::ST_HIGH: begin
            if (trig_i) begin
               s_next.cnt = aprt_pkg::PULSE_CNT_W'(CYCLES - 1);
            end else if (s_reg.cnt == '0) begin
               s_next.st = aprt_pkg::ST_IDLE;
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         default: begin
            s_next.st = aprt_pkg::ST_IDLE;
            s_next.cnt = '0;
         end
      endcase
      s_next.pulse = (s_next.st == aprt_pkg::ST_HIGH);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '{st: aprt_pkg::ST_IDLE, cnt: '0, pulse: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign pulse_o = s_reg.pulse;

   // helper: length of the current high phase; restarts on the first cycle of
   // every fresh count, so a retrigger does not add the overlap cycle
   logic [aprt_pkg::PULSE_CNT_W:0] hi_len;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_len <= '0;
      end else if (pulse_o && s_reg.cnt == aprt_pkg::PULSE_CNT_W'(CYCLES - 1)) begin
         hi_len <= {{aprt_pkg::PULSE_CNT_W{1'b0}}, 1'b1};
      end else if (pulse_o) begin
         hi_len <= hi_len + 1'b1;
      end
   end

   AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(pulse_o) |-> (hi_len == CYCLES))
      else $error("conversion pulse length wrong");

   AST_PULSE_START: assert property (@(posedge clk_i) disable iff (rst_i)
      trig_i |=> pulse_o [*8])
      else $error("conversion pulse did not start");

endmodule

`default_nettype wire

// [verification/aprt_host.sv]
// host model: register master that programs alert routing
`timescale 1ns/1ps
`default_nettype none

module aprt_host (
   // clock
   input wire logic clk_i,
   // register port
   output logic [aprt_pkg::ADDR_W-1:0] addr_o,
   output logic [aprt_pkg::DATA_W-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [aprt_pkg::DATA_W-1:0] rdata_i
);
   // idle bus at time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 24'h000000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // one-cycle write; lines scrambled after so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   // one-cycle read; data taken at the edge closing the answer cycle
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      d = rdata_i;
   endtask

   // alerts off while routing changes, so no false trigger slips out
   task automatic setup(input logic [23:0] r1, r2, en, input logic [1:0] fn);
      wr(aprt_pkg::OFS_ALERT_EN, 24'h000000);
      wr(aprt_pkg::OFS_ROUTE1, r1);
      wr(aprt_pkg::OFS_ROUTE2, r2);
      wr(aprt_pkg::OFS_PIN_FN, {22'h000000, fn});
      wr(aprt_pkg::OFS_ALERT_EN, en);
   endtask
endmodule
`default_nettype wire

// [verification/aprt_top_tb.sv]
// testbench for alert pin routing
`timescale 1ns/1ps
`default_nettype none

module aprt_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr;
   logic [23:0] wdata;
   logic wr;
   logic rd;
   logic [23:0] rdata;
   aprt_pkg::aprt_cond_t cond = '0;
   logic conv_done = 1'b0;
   logic pin1_in = 1'b0;
   logic pin1, pin1_oe_n, slow, pin2, pin2_oe_n, irq;
   int bad_count = 0;
   int comparisons = 0;

   // ----------------------------------------------------------------
   // clock, design and host
   // ----------------------------------------------------------------
   always #2 clk = ~clk;

   aprt_top u_aprt_top (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cond_i(cond), .conv_done_i(conv_done),
      .pin1_i(pin1_in), .pin1_o(pin1), .pin1_oe_n_o(pin1_oe_n), .slow_mode_o(slow),
      .pin2_o(pin2), .pin2_oe_n_o(pin2_oe_n), .irq_o(irq));

   aprt_host u_aprt_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .rdata_i(rdata));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
      logic [23:0] d;
      u_aprt_host.rd(a, d);
      chk(d, exp);
   endtask

   // pins are registered, so allow a few edges before looking
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // one conversion-done pulse, then count cycles each pin is high
   task automatic conv_count(output logic [23:0] n1, n2);
      n1 = 24'h000000;
      n2 = 24'h000000;
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (1400) begin
         @(posedge clk);
         #1;
         n1 += pin1;
         n2 += pin2;
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] ofs [6] = '{8'h27, 8'h28, 8'h40, 8'h41, 8'h43, 8'h10};
      logic [23:0] exp [6] = '{24'hFFFFFE, 24'hFFFFFE, 24'hFFFFFE, 24'h000003,
         24'h000007, 24'h000000};
      chk({pin1, pin2, irq, pin1_oe_n, pin2_oe_n}, 24'h000003);
      rd_chk(aprt_pkg::OFS_IRQ_STAT, 24'h000000);
      foreach (ofs[i]) rd_chk(ofs[i], 24'h000000);
      foreach (ofs[i]) u_aprt_host.wr(ofs[i], 24'hFFFFFF);
      foreach (ofs[i]) rd_chk(ofs[i], exp[i]);
   endtask

   // each condition bit alone, routed to one pin and not the other
   task automatic t_route();
      logic [23:0] b;
      for (int i = 2; i < 24; i++) begin
         b = 24'h000001 << i;
         u_aprt_host.setup(b, ~b & 24'hFFFFFC, 24'hFFFFFC, 2'h3);
         @(posedge clk);
         cond <= aprt_pkg::aprt_cond_t'(b[23:2]);
         settle();
         chk({pin1, pin2}, 24'h000002);
         @(posedge clk);
         cond <= aprt_pkg::aprt_cond_t'(~b[23:2]);
         settle();
         chk({pin1, pin2}, 24'h000001);
      end
   endtask

   task automatic t_gate();
      u_aprt_host.setup(24'hFFFFFC, 24'hFFFFFC, 24'h000000, 2'h3);
      cond <= '1;
      settle();
      chk({pin1, pin2}, 24'h000000);
      u_aprt_host.setup(24'hFFFFFC, 24'hFFFFFC, 24'hFFFFFC, 2'h0);
      pin1_in <= 1'b1;
      settle();
      chk({pin1, pin1_oe_n, pin2, pin2_oe_n, slow}, 24'h00000B);
      u_aprt_host.wr(aprt_pkg::OFS_PIN_FN, 24'h000001);
      settle();
      chk({pin1, pin1_oe_n, pin2, pin2_oe_n, slow}, 24'h000012);
      @(posedge clk);
      cond <= '0;
      pin1_in <= 1'b0;
   endtask

   // 5 us at 4 ns per cycle
   task automatic t_pulse();
      logic [23:0] n1, n2;
      u_aprt_host.setup(24'h000002, 24'h000002, 24'h000000, 2'h3);
      conv_count(n1, n2);
      chk(n1, 24'd5000 / 24'd4);
      chk(n2, 24'd5000 / 24'd4);
      u_aprt_host.setup(24'h000002, 24'h000000, 24'h000000, 2'h2);
      conv_count(n1, n2);
      chk(n1, 24'h000000);
      chk(n2, 24'h000000);
   endtask

   task automatic t_irq();
      u_aprt_host.wr(aprt_pkg::OFS_IRQ_STAT, 24'h000007);
      u_aprt_host.wr(aprt_pkg::OFS_IRQ_MASK, 24'h000001);
      settle();
      chk(irq, 24'h000000);
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      settle();
      chk(irq, 24'h000001);
      rd_chk(aprt_pkg::OFS_IRQ_STAT, 24'h000001);
      u_aprt_host.wr(aprt_pkg::OFS_IRQ_STAT, 24'h000001);
      settle();
      chk(irq, 24'h000000);
      u_aprt_host.wr(aprt_pkg::OFS_IRQ_MASK, 24'h000004);
      u_aprt_host.setup(24'h000000, 24'h800000, 24'h800000, 2'h3);
      cond <= aprt_pkg::aprt_cond_t'(22'h200000);
      settle();
      chk({pin2, irq}, 24'h000003);
      rd_chk(aprt_pkg::OFS_IRQ_STAT, 24'h000004);
   endtask

   // reset in mid-run clears routes and releases both pins
   task automatic t_reset();
      u_aprt_host.setup(24'hFFFFFC, 24'hFFFFFC, 24'hFFFFFC, 2'h3);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk({pin1, pin1_oe_n, pin2, pin2_oe_n, irq}, 24'h00000A);
      rd_chk(aprt_pkg::OFS_ROUTE1, 24'h000000);
      rd_chk(aprt_pkg::OFS_ROUTE2, 24'h000000);
   endtask

   // ----------------------------------------------------------------
   // verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // the run needs about 3400 cycles; allow about fifteen times that
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_regs();
      t_route();
      t_gate();
      t_pulse();
      t_irq();
      t_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
